// *** include/pcr_params.svh ***
`ifndef PCR_PARAMS_SVH
`define PCR_PARAMS_SVH
`define PCR_OFS_CONTROL 12'h000
`define PCR_OFS_IRQ_ENABLE 12'h004
`define PCR_OFS_IRQ_FLAGS 12'h008
`define PCR_OFS_CLOCK 12'h00C
`define PCR_OFS_RELOAD 12'h010
`define PCR_OFS_OFFSET 12'h014
`define PCR_OFS_STATUS 12'h018
`define PCR_CTL_EN_BIT 7
`define PCR_CTL_OE_BIT 6
`define PCR_CTL_OUT_BIT 5
`define PCR_CTL_POL_BIT 4
`define PCR_CTL_WMASK 8'hDC
`define PCR_IE_WMASK 8'h0F
`define PCR_CLK_WMASK 8'h73
`define PCR_LD_WMASK 8'hC3
`define PCR_OF_WMASK 8'h73
`define PCR_LD_ARM_BIT 7
`define PCR_LD_TRIG_BIT 6
`define PCR_OF_EDGE_BIT 4
`define PCR_RESET_BYTE 8'h00
`define PCR_SYNC_STAGES 3
`endif

// *** include/pcr_pkg.sv ***
package pcr_pkg;
	typedef enum logic [1:0] {PCR_SRC_SYS, PCR_SRC_FAST, PCR_SRC_SLOW, PCR_SRC_RSVD} pcr_src_t;
	typedef enum logic [1:0] {PCR_WAVE_STD, PCR_WAVE_SET, PCR_WAVE_TOGGLE, PCR_WAVE_CENTER} pcr_wave_t;
	typedef struct packed {
		logic phase;
		logic duty;
		logic period;
		logic offset_up;
		logic offset_down;
	} pcr_match_t;
	typedef struct packed {
		logic [15:0] phase;
		logic [15:0] duty;
		logic [15:0] period;
		logic [15:0] offset;
		logic offset_edge_select;
	} pcr_values_t;
endpackage

// *** core/pcr_sync.sv ***
`timescale 1ns/1ns
`include "pcr_params.svh"
module pcr_sync #(
	parameter int WIDTH = 1
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);
	// stage 0 is read only by stage 1; a change counts once stages 1 and 2 agree
	logic [`PCR_SYNC_STAGES-1:0][WIDTH-1:0] stages;
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			stages <= '0;
			dout <= '0;
		end
		else if (clk_en)
		begin
			stages <= {stages[`PCR_SYNC_STAGES-2:0], din};
			for (int i = 0; i < WIDTH; i++)
			begin
				if (stages[1][i] == stages[2][i])
				begin
					dout[i] <= stages[2][i];
				end
			end
		end
	end
endmodule

// *** core/pcr_channel_regs.sv ***
`timescale 1ns/1ns
`include "pcr_params.svh"
module pcr_channel_regs #(
	parameter logic [1:0] CHANNEL_ID = 2'h1
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic sleep_mode,
	input wire logic sys_osc_tick,
	input wire logic fast_osc_tick,
	input wire logic slow_osc_tick,
	input wire logic [3:1] sibling_offset_event,
	input wire logic [3:1] sibling_load_event,
	input wire pcr_pkg::pcr_match_t match_events,
	input wire logic waveform_level,
	input wire pcr_pkg::pcr_values_t shadow_values,
	output pcr_pkg::pcr_values_t active_values,
	output logic buffer_load_event,
	output logic timer_tick,
	output logic selected_offset_event,
	output logic offset_match_out,
	output logic channel_enable,
	output pcr_pkg::pcr_wave_t wave_mode,
	output logic [1:0] slave_run_kind,
	output logic pwm_pin_out,
	output logic pwm_pin_oe,
	output logic irq
);
	typedef struct packed {
		logic [7:0] control;
		logic [7:0] irq_enable;
		logic [7:0] irq_flags;
		logic [7:0] clock_control;
		logic [7:0] reload_control;
		logic [7:0] offset_control;
		logic trigger_seen;
		pcr_pkg::pcr_match_t match_prev;
		logic [6:0] prescale_count;
		logic tick;
		logic load_pulse;
		pcr_pkg::pcr_values_t active;
		logic [31:0] rdata;
	} pcr_state_t;

	pcr_state_t st;
	pcr_state_t next_st;
	logic [3:1] load_sync;
	logic [3:1] offset_sync;
	logic [3:1] load_prev;
	logic [3:1] offset_prev;
	logic [3:1] load_rise;
	logic [3:1] offset_rise;
	logic [2:0] reg_sel;
	logic access;
	logic wr;
	logic [7:0] wbyte;
	logic source_tick;
	logic [6:0] prescale_limit;
	logic period_end;
	logic trigger_now;
	logic [3:0] raw_events;
	logic [3:0] event_rise;
	logic offset_match;
	logic prev_offset_match;

	// a valid source code names a sibling, never the channel itself
	function automatic logic pick_sibling(input logic [1:0] code, input logic [3:1] events);
		logic result;
		result = 1'b0;
		if (code != 2'h0 && code != CHANNEL_ID)
		begin
			result = events[code];
		end
		return result;
	endfunction

	// address decode shared by the read and write paths; unmapped words give 3'h7
	function automatic logic [2:0] reg_index(input logic [11:0] addr);
		logic [2:0] idx;
		idx = 3'h7;
		case (addr)
			`PCR_OFS_CONTROL: idx = 3'h0;
			`PCR_OFS_IRQ_ENABLE: idx = 3'h1;
			`PCR_OFS_IRQ_FLAGS: idx = 3'h2;
			`PCR_OFS_CLOCK: idx = 3'h3;
			`PCR_OFS_RELOAD: idx = 3'h4;
			`PCR_OFS_OFFSET: idx = 3'h5;
			`PCR_OFS_STATUS: idx = 3'h6;
			default: idx = 3'h7;
		endcase
		return idx;
	endfunction

	pcr_sync #(.WIDTH(6)) u_sync (
		.sys_clk(sys_clk),
		.rst(rst),
		.clk_en(clk_en),
		.din({sibling_load_event, sibling_offset_event}),
		.dout({load_sync, offset_sync})
	);

	assign reg_sel = reg_index(paddr);
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			load_prev <= 3'h0;
			offset_prev <= 3'h0;
		end
		else if (clk_en)
		begin
			load_prev <= load_sync;
			offset_prev <= offset_sync;
		end
	end
	// one edge detector per sibling line; synchroniser and history both idle low, so no false edge after reset
	for (genvar g = 1; g <= 3; g++)
	begin : g_sib_edge
		assign load_rise[g] = load_sync[g] & ~load_prev[g];
		assign offset_rise[g] = offset_sync[g] & ~offset_prev[g];
	end

	assign access = psel && penable;
	assign wr = access && pwrite;
	assign wbyte = pwdata[7:0];
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign prdata = st.rdata;

	// offset event follows the buffered edge bit only in center-aligned mode
	assign offset_match = (st.control[3:2] == 2'h3) ?
		(st.active.offset_edge_select ? match_events.offset_down : match_events.offset_up) :
		match_events.offset_up;
	assign raw_events = {offset_match, match_events.phase, match_events.duty, match_events.period};
	// history of the offset event uses the same selection, so a held up match cannot mask a down rise
	assign prev_offset_match = (st.control[3:2] == 2'h3) ?
		(st.active.offset_edge_select ? st.match_prev.offset_down : st.match_prev.offset_up) :
		st.match_prev.offset_up;
	assign event_rise = raw_events & ~{prev_offset_match,
		st.match_prev.phase, st.match_prev.duty, st.match_prev.period};

	always_comb
	begin
		unique case (pcr_pkg::pcr_src_t'(st.clock_control[1:0]))
			pcr_pkg::PCR_SRC_SYS: source_tick = sys_osc_tick && !sleep_mode;
			pcr_pkg::PCR_SRC_FAST: source_tick = fast_osc_tick;
			pcr_pkg::PCR_SRC_SLOW: source_tick = slow_osc_tick;
			default: source_tick = 1'b0;
		endcase
	end
	assign prescale_limit = 7'((8'h1 << st.clock_control[6:4]) - 8'h1);

	// period end is the rise of the period match, so a match held high reloads only once
	assign period_end = match_events.period && !st.match_prev.period;
	assign trigger_now = pick_sibling(st.reload_control[1:0], load_rise);

	always_comb
	begin
		next_st = st;
		next_st.match_prev = match_events;
		next_st.load_pulse = 1'b0;
		next_st.tick = 1'b0;
		if (st.control[`PCR_CTL_EN_BIT] && source_tick)
		begin
			if (st.prescale_count >= prescale_limit)
			begin
				next_st.prescale_count = 7'h0;
				next_st.tick = 1'b1;
			end
			else
			begin
				next_st.prescale_count = st.prescale_count + 7'h1;
			end
		end
		if (!st.control[`PCR_CTL_EN_BIT])
		begin
			next_st.prescale_count = 7'h0;
		end
		// trigger latch only matters in trigger mode
		if (!st.reload_control[`PCR_LD_TRIG_BIT])
		begin
			next_st.trigger_seen = 1'b0;
		end
		else if (trigger_now)
		begin
			next_st.trigger_seen = 1'b1;
		end
		if (period_end && st.reload_control[`PCR_LD_ARM_BIT] &&
			(!st.reload_control[`PCR_LD_TRIG_BIT] || st.trigger_seen))
		begin
			next_st.active = shadow_values;
			next_st.load_pulse = 1'b1;
			next_st.reload_control[`PCR_LD_ARM_BIT] = 1'b0;
			next_st.trigger_seen = 1'b0;
		end
		next_st.rdata = 32'h0;
		// read word is captured in the setup cycle so it stands at the zero-wait access edge
		if (psel && !penable && !pwrite)
		begin
			case (reg_sel)
				3'h0: next_st.rdata = {24'h0, st.control[7:6], waveform_level, st.control[4:0]};
				3'h1: next_st.rdata = {24'h0, st.irq_enable};
				3'h2: next_st.rdata = {24'h0, st.irq_flags};
				3'h3: next_st.rdata = {24'h0, st.clock_control};
				3'h4: next_st.rdata = {24'h0, st.reload_control};
				3'h5: next_st.rdata = {24'h0, st.offset_control};
				3'h6: next_st.rdata = {31'h0, st.trigger_seen};
				default: next_st.rdata = 32'h0;
			endcase
		end
		if (wr)
		begin
			case (reg_sel)
				3'h0: next_st.control = wbyte & `PCR_CTL_WMASK;
				3'h1: next_st.irq_enable = wbyte & `PCR_IE_WMASK;
				3'h2: next_st.irq_flags = wbyte & `PCR_IE_WMASK;
				3'h3: next_st.clock_control = wbyte & `PCR_CLK_WMASK;
				3'h4:
				begin
					next_st.reload_control = wbyte & `PCR_LD_WMASK;
					// arming on the period-end cycle must not load on that same edge
					if (period_end && wbyte[`PCR_LD_ARM_BIT] && !st.reload_control[`PCR_LD_ARM_BIT])
					begin
						next_st.reload_control[`PCR_LD_ARM_BIT] = 1'b1;
					end
				end
				3'h5: next_st.offset_control = wbyte & `PCR_OF_WMASK;
				default: next_st = next_st;
			endcase
		end
		// hardware set wins over a software clear in the same cycle
		next_st.irq_flags[3:0] = next_st.irq_flags[3:0] | event_rise;
		if (!st.control[`PCR_CTL_EN_BIT])
		begin
			next_st.irq_flags = 8'h0;
		end
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			st <= '0;
		end
		else if (clk_en)
		begin
			st <= next_st;
		end
	end

	assign active_values = st.active;
	assign buffer_load_event = st.load_pulse;
	assign timer_tick = st.tick;
	assign selected_offset_event = pick_sibling(st.offset_control[1:0], offset_rise);
	assign offset_match_out = offset_match;
	assign channel_enable = st.control[`PCR_CTL_EN_BIT];
	assign wave_mode = pcr_pkg::pcr_wave_t'(st.control[3:2]);
	assign slave_run_kind = st.offset_control[6:5];
	assign pwm_pin_out = waveform_level ^ st.control[`PCR_CTL_POL_BIT];
	assign pwm_pin_oe = st.control[`PCR_CTL_OE_BIT] && st.control[`PCR_CTL_EN_BIT];
	assign irq = |(st.irq_flags[3:0] & st.irq_enable[3:0]);
endmodule

// *** verif/pcr_monitor.sv ***
`timescale 1ns/1ns
module pcr_monitor (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic sleep_mode,
	input wire logic sys_osc_tick,
	input wire logic fast_osc_tick,
	input wire logic slow_osc_tick,
	input wire pcr_pkg::pcr_match_t match_events,
	input wire pcr_pkg::pcr_values_t shadow_values,
	input wire pcr_pkg::pcr_values_t active_values,
	input wire logic buffer_load_event,
	input wire logic timer_tick,
	input wire logic selected_offset_event,
	input wire logic channel_enable,
	input wire logic pwm_pin_oe,
	input wire logic irq
);
	logic src;
	logic per;
	// system source is gated in sleep, internal ones are not
	assign src = fast_osc_tick | slow_osc_tick | (sys_osc_tick & ~sleep_mode);
	assign per = match_events.period;
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (rst);
	a_tick_has_source: assert property (timer_tick |-> $past(src) || $past(src, 2))
		else $error("prescaled tick without a source tick");
	a_load_on_period: assert property (buffer_load_event |-> $past(per) && !$past(per, 2))
		else $error("reload not tied to period rise");
	a_load_copies_shadow: assert property (buffer_load_event |-> active_values == $past(shadow_values))
		else $error("reload did not copy buffers");
	a_active_held: assert property (!buffer_load_event |-> $stable(active_values))
		else $error("active values moved without reload");
	a_irq_off_disabled: assert property ((!channel_enable)[*2] |-> !irq)
		else $error("request while channel disabled");
	a_oe_needs_enable: assert property (pwm_pin_oe |-> channel_enable)
		else $error("pin driven while channel off");
	a_offset_single: assert property (selected_offset_event |=> !selected_offset_event)
		else $error("offset event longer than one cycle");
	a_bus_no_error: assert property (pready && !pslverr)
		else $error("bus wait or error response");
endmodule

// *** verif/pcr_sib_model.sv ***
`timescale 1ns/1ns
module pcr_sib_model (
	input wire logic sys_clk,
	output logic [3:1] sibling_load_event,
	output logic [3:1] sibling_offset_event
);
	initial
	begin
		sibling_load_event = 3'h0;
		sibling_offset_event = 3'h0;
	end
	// held six cycles so the three-flop sync cannot miss it
	task automatic fire(input logic ofs, input int ch);
		@(posedge sys_clk);
		if (ofs)
			sibling_offset_event[ch] <= 1'h1;
		else
			sibling_load_event[ch] <= 1'h1;
		repeat (6) @(posedge sys_clk);
		sibling_offset_event <= 3'h0;
		sibling_load_event <= 3'h0;
	endtask
endmodule

// *** verif/pcr_channel_regs_test.sv ***
`timescale 1ns/1ns
module pcr_channel_regs_test;
	logic sys_clk, rst, psel, penable, pwrite, sleep_mode, sys_osc_tick, fast_osc_tick, slow_osc_tick;
	logic waveform_level, pready, buffer_load_event, timer_tick, selected_offset_event, pwm_pin_out, pwm_pin_oe, irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [3:1] sibling_load_event, sibling_offset_event;
	pcr_pkg::pcr_match_t match_events;
	pcr_pkg::pcr_values_t shadow_values, active_values;
	pcr_pkg::pcr_wave_t wave_mode;
	logic channel_enable, offset_match_out;
	logic [1:0] slave_run_kind;
	int fails, checked, loads, ticks, hits, n;
	localparam logic [7:0] MASK [6] = '{8'hDC, 8'h0F, 8'h0F, 8'h73, 8'hC3, 8'h73};
	pcr_channel_regs dut (.sys_clk, .rst, .clk_en(1'h1), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr(), .sleep_mode, .sys_osc_tick, .fast_osc_tick, .slow_osc_tick, .sibling_offset_event,
		.sibling_load_event, .match_events, .waveform_level, .shadow_values, .active_values, .buffer_load_event,
		.timer_tick, .selected_offset_event, .offset_match_out, .channel_enable, .wave_mode,
		.slave_run_kind, .pwm_pin_out, .pwm_pin_oe, .irq);
	pcr_sib_model sib (.sys_clk, .sibling_load_event, .sibling_offset_event);
	initial
	begin
		sys_clk = 1'h0;
		forever #2 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk)
	begin
		loads += int'(buffer_load_event === 1'h1);
		ticks += int'(timer_tick === 1'h1);
		hits += int'(selected_offset_event === 1'h1);
	end
	task automatic chk(input string s, input logic [31:0] v, input logic [31:0] e);
		checked++;
		if (v !== e)
		begin
			fails++;
			$display("MISMATCH %s exp %h got %h", s, e, v);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge sys_clk);
		penable <= 1'h1;
		@(posedge sys_clk);
		while (pready !== 1'h1)
			@(posedge sys_clk);
		q = prdata;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge sys_clk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		apb(1'h1, a, d);
	endtask
	task automatic rd(input string s, input logic [11:0] a, input logic [31:0] e);
		apb(1'h0, a, 8'h0);
		chk(s, q, e);
	endtask
	task automatic per();
		match_events.period <= 1'h1;
		repeat (3) @(posedge sys_clk);
		match_events.period <= 1'h0;
		repeat (3) @(posedge sys_clk);
	endtask
	task automatic t_regs();
		wr(12'h01C, 8'hFF);
		rd("unmapped", 12'h01C, 32'h0);
		for (int i = 0; i < 6; i++)
			rd("reset", 12'(i * 4), 32'h0);
		for (int i = 0; i < 6; i++)
			wr(12'(i * 4), 8'hFF);
		for (int i = 0; i < 6; i++)
			rd("mask", 12'(i * 4), {24'h0, MASK[i]});
		chk("mode", wave_mode, 32'h3);
		chk("slave", slave_run_kind, 32'h3);
		chk("enable", channel_enable, 32'h1);
		chk("irq", irq, 32'h1);
		chk("oe", pwm_pin_oe, 32'h1);
		chk("pin", pwm_pin_out, 32'h1);
		waveform_level <= 1'h1;
		rd("out", 12'h000, 32'hFC);
		chk("pin", pwm_pin_out, 32'h0);
		wr(12'h000, 8'h00);
		rd("flags", 12'h008, 32'h0);
		for (int i = 1; i < 6; i++)
			wr(12'(i * 4), 8'h00);
		waveform_level <= 1'h0;
	endtask
	task automatic t_flags();
		logic [4:0] v [4];
		logic [7:0] f [4];
		v = '{5'h10, 5'h08, 5'h04, 5'h03};
		f = '{8'h04, 8'h02, 8'h01, 8'h08};
		wr(12'h000, 8'h80);
		for (int i = 0; i < 4; i++)
		begin
			match_events <= v[i];
			repeat (3) @(posedge sys_clk);
			rd("flag", 12'h008, {24'h0, f[i]});
			chk("masked", irq, 32'h0);
			wr(12'h004, f[i]);
			chk("irq", irq, 32'h1);
			wr(12'h008, 8'h00);
			rd("held", 12'h008, 32'h0);
			wr(12'h004, 8'h00);
			match_events <= 5'h00;
			@(posedge sys_clk);
		end
	endtask
	task automatic t_load();
		shadow_values <= {16'h1234, 16'h5678, 16'h9ABC, 16'hDEF0, 1'h1};
		n = loads;
		per();
		wr(12'h010, 8'h80);
		wr(12'h010, 8'h00);
		per();
		chk("noload", 32'(loads - n), 32'h0);
		chk("active", {active_values.period, active_values.offset}, 32'h0);
		wr(12'h010, 8'h83);
		per();
		chk("load", 32'(loads - n), 32'h1);
		chk("active", {active_values.period, active_values.offset}, 32'h9ABCDEF0);
		rd("disarm", 12'h010, 32'h03);
		wr(12'h010, 8'hC1);
		sib.fire(1'h0, 1);
		per();
		wr(12'h010, 8'hC2);
		per();
		chk("wait", 32'(loads - n), 32'h1);
		sib.fire(1'h0, 2);
		per();
		chk("trig", 32'(loads - n), 32'h2);
		rd("disarm", 12'h010, 32'h42);
		n = loads;
		fork
			wr(12'h010, 8'h80);
			begin
				@(posedge sys_clk);
				match_events.period <= 1'h1;
			end
		join
		match_events.period <= 1'h0;
		@(posedge sys_clk);
		chk("late", 32'(loads - n), 32'h0);
		per();
		chk("next", 32'(loads - n), 32'h1);
		chk("edge", active_values.offset_edge_select, 32'h1);
		wr(12'h000, 8'h8C);
		match_events <= 5'h01;
		@(posedge sys_clk);
		chk("ofsdown", offset_match_out, 32'h1);
		match_events <= 5'h02;
		@(posedge sys_clk);
		chk("ofsup", offset_match_out, 32'h0);
		wr(12'h000, 8'h80);
		chk("ofsplain", offset_match_out, 32'h1);
		match_events <= 5'h00;
	endtask
	task automatic t_tick();
		logic [7:0] cs [5];
		logic [7:0] ex [5];
		cs = '{8'h00, 8'h00, 8'h01, 8'h12, 8'h03};
		ex = '{8'h08, 8'h00, 8'h08, 8'h04, 8'h00};
		for (int i = 0; i < 5; i++)
		begin
			sleep_mode <= (i > 0);
			wr(12'h00C, cs[i]);
			n = ticks;
			repeat (8)
			begin
				{sys_osc_tick, fast_osc_tick, slow_osc_tick} <= 3'h7;
				@(posedge sys_clk);
				{sys_osc_tick, fast_osc_tick, slow_osc_tick} <= 3'h0;
				repeat (2) @(posedge sys_clk);
			end
			repeat (4) @(posedge sys_clk);
			chk("ticks", 32'(ticks - n), {24'h0, ex[i]});
		end
		sleep_mode <= 1'h0;
	endtask
	task automatic t_ofs();
		for (int i = 0; i < 3; i++)
		begin
			wr(12'h014, 8'(2 - i));
			n = hits;
			sib.fire(1'h1, 2 - i + 2 * int'(i == 2));
			chk("ofs", 32'(hits - n), 32'(i == 0));
		end
	endtask
	task automatic complete_run();
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial
	begin
		#200000;
		fails++;
		complete_run();
	end
	initial
	begin
		{rst, psel, penable, pwrite, sleep_mode, waveform_level} = 6'h21;
		{sys_osc_tick, fast_osc_tick, slow_osc_tick, paddr, pwdata} = '0;
		{match_events, shadow_values} = '0;
		{fails, checked, loads, ticks, hits} = '0;
		waveform_level = 1'h0;
		repeat (16) @(posedge sys_clk);
		rst <= 1'h0;
		@(posedge sys_clk);
		t_regs();
		t_flags();
		t_load();
		t_tick();
		t_ofs();
		wr(12'h000, 8'h80);
		rst <= 1'h1;
		repeat (2) @(posedge sys_clk);
		rst <= 1'h0;
		@(posedge sys_clk);
		rd("rereset", 12'h000, 32'h0);
		complete_run();
	end
endmodule
bind pcr_channel_regs pcr_monitor mon (.*);
